// ---- conv_seq_pkg.sv ----
// Shared constants, types and register map of the conversion sequencer
package conv_seq_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int RES_W  = 16;
  localparam int RAW_W  = 20;
  localparam int CAL_W  = 16;
  localparam int CORR_W = 24;
  localparam int TICK_W = 16;
  localparam int IRQ_W  = 2;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [APB_AW-1:0] OFS_CONFIG = 8'h00;
  localparam logic [APB_AW-1:0] OFS_RESULT = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] OFS_MASK   = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_SLAVE  = 8'h10;
  localparam int CFG_START_BIT  = 7;
  localparam int CFG_SINGLE_BIT = 4;
  localparam int CFG_RATE_LSB   = 2;
  localparam int CFG_GAIN_LSB   = 0;
  localparam int IRQ_DONE       = 0;
  localparam int IRQ_IGNORED    = 1;

  // ************************************************************
  // General call commands, calibration, pin settling
  // ************************************************************
  localparam logic [7:0] GC_LATCH_RESET = 8'h06;
  localparam logic [7:0] GC_LATCH_ONLY  = 8'h04;
  localparam int         CAL_FRAC       = 14;
  localparam logic [1:0] PIN_SETTLE     = 2'h3;

  // ************************************************************
  // Data rates: result width and conversion length multiplier
  // ************************************************************
  typedef enum logic [1:0] {
    RATE_240 = 2'b00,
    RATE_60  = 2'b01,
    RATE_30  = 2'b10,
    RATE_15  = 2'b11
  } rate_t;
  localparam int BITS_15  = 16;
  localparam int BITS_30  = 15;
  localparam int BITS_60  = 14;
  localparam int BITS_240 = 12;
  localparam int LEN_SH_15  = 4;
  localparam int LEN_SH_30  = 3;
  localparam int LEN_SH_60  = 2;
  localparam int LEN_SH_240 = 0;

  typedef enum logic {
    ST_DOWN = 1'b0,
    ST_CONV = 1'b1
  } conv_state_t;

  typedef struct packed {
    logic       start;
    logic       single;
    rate_t      rate;
    logic [1:0] gain;
  } config_t;
  localparam config_t CFG_DEFAULT = '{start: 1'h0, single: 1'h0,
                                      rate: RATE_15, gain: 2'h0};

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    conv_state_t       st;
    config_t           cfg;
    logic [RES_W-1:0]  result;
    logic [IRQ_W-1:0]  status;
    logic [IRQ_W-1:0]  mask;
    logic [TICK_W-1:0] ticks;
    logic [2:0]        osc_s;
    logic [1:0]        pin_s1;
    logic [1:0]        pin_s2;
    logic [1:0]        pin_cnt;
    logic [1:0]        slave_sel;
  } seq_state_t;

endpackage : conv_seq_pkg

// ---- conv_seq.sv ----
// Conversion sequencer and output code formatter with APB registers
`timescale 1ns/10ps
module conv_seq
  import conv_seq_pkg::*;
#(
  parameter int CONV_TICKS = 16
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // APB slave
  input  wire conv_seq_pkg::apb_req_t apb_i,
  output conv_seq_pkg::apb_rsp_t      apb_o,
  // Oscillator and analog side
  input  wire logic                   osc_i,
  input  wire logic [conv_seq_pkg::RAW_W-1:0] raw_code_i,
  input  wire logic [conv_seq_pkg::RAW_W-1:0] cal_offset_i,
  input  wire logic [conv_seq_pkg::CAL_W-1:0] cal_gain_i,
  output logic                        power_up_o,
  output logic [1:0]                  input_gain_factor_o,
  // Bus slave side: general call and address pins
  input  wire logic                   gc_valid_i,
  input  wire logic [7:0]             gc_byte_i,
  input  wire logic [1:0]             addr_pins_i,
  output logic [1:0]                  slave_sel_o,
  // Interrupt
  output logic                        irq_o
);
  import conv_seq_pkg::*;

  // ************************************************************
  // Code formatting
  // ************************************************************
  function automatic int rate_bits(input rate_t r);
    int b;
    b = BITS_15;
    unique case (r)
      RATE_15:  b = BITS_15;
      RATE_30:  b = BITS_30;
      RATE_60:  b = BITS_60;
      RATE_240: b = BITS_240;
    endcase
    return b;
  endfunction : rate_bits

  function automatic logic signed [CORR_W-1:0] max_code(input rate_t r);
    return CORR_W'((1 <<< (rate_bits(r) - 1)) - 1);
  endfunction : max_code

  // Drops low bits for lower widths, clips, then sign-extends
  function automatic logic [RES_W-1:0] fmt_code(
    input logic signed [CORR_W-1:0] v,
    input rate_t                    r
  );
    logic signed [CORR_W-1:0] s;
    logic signed [CORR_W-1:0] hi;
    logic signed [CORR_W-1:0] lo;
    s  = v >>> (RES_W - rate_bits(r));
    hi = max_code(r);
    lo = ~hi;
    if (s > hi) begin
      s = hi;
    end else if (s < lo) begin
      s = lo;
    end
    return s[RES_W-1:0];
  endfunction : fmt_code

  function automatic logic [TICK_W-1:0] conv_len(input rate_t r);
    int sh;
    sh = LEN_SH_15;
    unique case (r)
      RATE_15:  sh = LEN_SH_15;
      RATE_30:  sh = LEN_SH_30;
      RATE_60:  sh = LEN_SH_60;
      RATE_240: sh = LEN_SH_240;
    endcase
    return TICK_W'(CONV_TICKS << sh);
  endfunction : conv_len

  function automatic seq_state_t reset_state(input logic [2:0] osc_s);
    seq_state_t s;
    s         = '0;
    s.st      = ST_DOWN;
    s.cfg     = CFG_DEFAULT;
    s.osc_s   = osc_s;
    return s;
  endfunction : reset_state

  // ************************************************************
  // Calibration path
  // ************************************************************
  logic signed [RAW_W:0]          cal_diff;
  logic signed [RAW_W+CAL_W+1:0]  cal_prod;
  logic signed [CORR_W-1:0]       corr_code;

  always_comb begin
    cal_diff  = $signed({raw_code_i[RAW_W-1], raw_code_i})
              - $signed({cal_offset_i[RAW_W-1], cal_offset_i});
    cal_prod  = cal_diff * $signed({1'h0, cal_gain_i});
    corr_code = CORR_W'(cal_prod >>> CAL_FRAC);
  end

  // ************************************************************
  // Sequencer, register file and events
  // ************************************************************
  seq_state_t       r;
  seq_state_t       r_nxt;
  logic             osc_tick;
  logic             access;
  logic             wr_cfg;
  logic             done_ev;
  logic             ign_ev;
  logic             gc_reset;
  logic [IRQ_W-1:0] ev_set;
  logic [IRQ_W-1:0] st_clr;

  always_comb begin
    r_nxt    = r;
    // The second and third stages feed the edge detector
    r_nxt.osc_s = {r.osc_s[1:0], osc_i};
    osc_tick = r.osc_s[1] & ~r.osc_s[2];
    access   = apb_i.psel & apb_i.penable;
    wr_cfg   = access & apb_i.pwrite & (apb_i.paddr == OFS_CONFIG);
    done_ev  = 1'h0;
    ign_ev   = 1'h0;
    st_clr   = '0;
    gc_reset = gc_valid_i & (gc_byte_i == GC_LATCH_RESET);

    // Address pins settle through two stages before being caught
    r_nxt.pin_s1 = addr_pins_i;
    r_nxt.pin_s2 = r.pin_s1;
    if (r.pin_cnt != PIN_SETTLE) begin
      r_nxt.pin_cnt = r.pin_cnt + 2'h1;
      if (r.pin_cnt == PIN_SETTLE - 2'h1) begin
        r_nxt.slave_sel = r.pin_s2;
      end
    end

    // Configuration write; the start flag is ignored while busy
    if (wr_cfg) begin
      r_nxt.cfg.single = apb_i.pwdata[CFG_SINGLE_BIT];
      r_nxt.cfg.rate   = rate_t'(apb_i.pwdata[CFG_RATE_LSB +: 2]);
      r_nxt.cfg.gain   = apb_i.pwdata[CFG_GAIN_LSB +: 2];
      if (apb_i.pwdata[CFG_START_BIT]) begin
        if (r.st == ST_DOWN) begin
          r_nxt.cfg.start = 1'h1;
        end else begin
          ign_ev = 1'h1;
        end
      end
    end

    unique case (r.st)
      ST_DOWN: begin
        if (!r.cfg.single || r.cfg.start) begin
          r_nxt.st    = ST_CONV;
          r_nxt.ticks = '0;
        end
      end
      ST_CONV: begin
        if (osc_tick) begin
          if (r.ticks >= conv_len(r.cfg.rate) - TICK_W'(1)) begin
            done_ev      = 1'h1;
            r_nxt.result = fmt_code(corr_code, r.cfg.rate);
            r_nxt.ticks  = '0;
            if (r.cfg.single) begin
              r_nxt.cfg.start = 1'h0;
              r_nxt.st        = ST_DOWN;
            end
          end else begin
            r_nxt.ticks = r.ticks + TICK_W'(1);
          end
        end
      end
    endcase

    // Status: set wins over a write-one clear in the same cycle
    if (access && apb_i.pwrite && apb_i.paddr == OFS_STATUS) begin
      st_clr = apb_i.pwdata[IRQ_W-1:0];
    end
    if (access && apb_i.pwrite && apb_i.paddr == OFS_MASK) begin
      r_nxt.mask = apb_i.pwdata[IRQ_W-1:0];
    end
    ev_set = '0;
    ev_set[IRQ_DONE]    = done_ev;
    ev_set[IRQ_IGNORED] = ign_ev;
    r_nxt.status = (r.status & ~st_clr) | ev_set;

    // General call: 06h resets like power-up, both relatch pins
    if (gc_reset) begin
      r_nxt = reset_state(r_nxt.osc_s);
    end
    if (gc_valid_i && (gc_byte_i == GC_LATCH_RESET
                       || gc_byte_i == GC_LATCH_ONLY)) begin
      r_nxt.pin_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= reset_state(3'h0);
    end else begin
      r <= r_nxt;
    end
  end

  // ************************************************************
  // APB answer and outputs
  // ************************************************************
  always_comb begin
    apb_o.pready  = 1'h1;
    apb_o.pslverr = 1'h0;
    apb_o.prdata  = '0;
    unique case (apb_i.paddr)
      OFS_CONFIG: begin
        apb_o.prdata[CFG_START_BIT]       = r.cfg.start;
        apb_o.prdata[CFG_SINGLE_BIT]      = r.cfg.single;
        apb_o.prdata[CFG_RATE_LSB +: 2]   = r.cfg.rate;
        apb_o.prdata[CFG_GAIN_LSB +: 2]   = r.cfg.gain;
      end
      OFS_RESULT: apb_o.prdata[RES_W-1:0] = r.result;
      OFS_STATUS: apb_o.prdata[IRQ_W-1:0] = r.status;
      OFS_MASK:   apb_o.prdata[IRQ_W-1:0] = r.mask;
      OFS_SLAVE:  apb_o.prdata[1:0]       = r.slave_sel;
      default:    apb_o.pslverr           = apb_i.psel & apb_i.penable;
    endcase
  end

  assign power_up_o          = (r.st == ST_CONV);
  assign input_gain_factor_o = r.cfg.gain;
  assign slave_sel_o         = r.slave_sel;
  assign irq_o               = |(r.status & r.mask);

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_single_end;
    (r.st == ST_CONV) && done_ev && r.cfg.single && !gc_reset;
  endsequence

  sequence s_powered_down;
    !r.cfg.start && (r.st == ST_DOWN) && !power_up_o;
  endsequence

  property p_single_end;
    @(posedge clk_i) disable iff (reset_i)
      s_single_end |=> s_powered_down;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single-shot end did not clear flag and power down");

  property p_cont_restart;
    @(posedge clk_i) disable iff (reset_i)
      done_ev && !r.cfg.single && !gc_reset
      |=> (r.st == ST_CONV) && (r.ticks == '0);
  endproperty
  a_cont_restart: assert property (p_cont_restart)
    else $error("continuous mode did not restart at once");

  property p_single_idle;
    @(posedge clk_i) disable iff (reset_i)
      (r.st == ST_DOWN) && r.cfg.single && !r.cfg.start && !wr_cfg
      && !gc_reset |=> (r.st == ST_DOWN);
  endproperty
  a_single_idle: assert property (p_single_idle)
    else $error("single-shot left power-down without a start");

  property p_start_ignored;
    @(posedge clk_i) disable iff (reset_i)
      (r.st == ST_CONV) && wr_cfg && apb_i.pwdata[CFG_START_BIT]
      && !done_ev && !gc_reset
      |=> (r.st == ST_CONV) && (r.ticks >= $past(r.ticks)) && r.status[1];
  endproperty
  a_start_ignored: assert property (p_start_ignored)
    else $error("start during conversion was not ignored");

  property p_code_range;
    @(posedge clk_i) disable iff (reset_i)
      done_ev && !gc_reset |=>
        ($signed(r.result) <= max_code($past(r.cfg.rate)))
        && ($signed(r.result) >= ~max_code($past(r.cfg.rate)));
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("result outside the range of the active width");

  property p_full_scale;
    @(posedge clk_i) disable iff (reset_i)
      done_ev && !gc_reset && (r.cfg.rate == RATE_240)
      && (corr_code < -$signed(CORR_W'(32768))) |=> (r.result == 16'hf800);
  endproperty
  a_full_scale: assert property (p_full_scale)
    else $error("negative full scale code wrong at highest rate");

  property p_atomic;
    @(posedge clk_i) disable iff (reset_i)
      !$stable(r.result) |-> $past(done_ev) || $past(gc_reset);
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("result changed outside conversion end");

  property p_gc_reset;
    @(posedge clk_i) disable iff (reset_i)
      gc_reset |=> (r.cfg == CFG_DEFAULT) && (r.status == '0)
                   && (r.st == ST_DOWN) ##1 (r.pin_cnt == 2'h1);
  endproperty
  a_gc_reset: assert property (p_gc_reset)
    else $error("general-call reset did not restore defaults");

  property p_por;
    @(posedge clk_i) disable iff (reset_i)
      $fell(reset_i) |-> (r.cfg == CFG_DEFAULT) && (r.mask == '0);
  endproperty
  a_por: assert property (p_por)
    else $error("configuration not at default after reset");

  property p_osc_only;
    @(posedge clk_i) disable iff (reset_i)
      (r.st == ST_CONV) && !osc_tick && !gc_reset |=> $stable(r.ticks);
  endproperty
  a_osc_only: assert property (p_osc_only)
    else $error("conversion advanced without an oscillator edge");

endmodule : conv_seq

// ---- gc_host_model.sv ----
// Host side model: general call commands and address pin levels
`timescale 1ns/10ps
module gc_host_model (
  // Clock
  input  wire logic       clk_i,
  // Towards the block
  output logic            gc_valid_o,
  output logic [7:0]      gc_byte_o,
  output logic [1:0]      addr_pins_o
);
  initial begin
    gc_valid_o  = 1'b0;
    gc_byte_o   = 8'h00;
    addr_pins_o = 2'h1;
  end

  // ******
  // Commands
  // ******
  // Byte means nothing outside the pulse, so it shows the inverse then
  task automatic send_gc(input logic [7:0] b);
    @(posedge clk_i);
    gc_valid_o <= 1'b1;
    gc_byte_o  <= b;
    @(posedge clk_i);
    gc_valid_o <= 1'b0;
    gc_byte_o  <= ~b;
  endtask : send_gc

  task automatic set_pins(input logic [1:0] p);
    @(posedge clk_i);
    addr_pins_o <= p;
  endtask : set_pins
endmodule : gc_host_model

// ---- conv_seq_test.sv ----
// Self-checking bench of the conversion sequencer
`timescale 1ns/10ps
module conv_seq_test;
  import conv_seq_pkg::*;
  // Short base length keeps the slowest rate near 256 clocks
  localparam int TICKS = 2;
  logic             clk;
  logic             reset;
  apb_req_t         req;
  apb_rsp_t         rsp;
  logic             osc;
  logic [RAW_W-1:0] raw;
  logic [RAW_W-1:0] ofs;
  logic [CAL_W-1:0] gn;
  logic             pwr;
  logic [1:0]       gain;
  logic             gc_v;
  logic [7:0]       gc_b;
  logic [1:0]       pins;
  logic [1:0]       sel;
  logic             irq;
  logic [31:0]      rd;
  logic             err;
  int               fail_count;
  int               samples_checked;

  always #25 clk = ~clk;
  always #200 osc = ~osc;

  conv_seq #(.CONV_TICKS(TICKS)) conv_seq_i (
    .clk_i(clk), .reset_i(reset), .apb_i(req), .apb_o(rsp),
    .osc_i(osc), .raw_code_i(raw), .cal_offset_i(ofs), .cal_gain_i(gn),
    .power_up_o(pwr), .input_gain_factor_o(gain),
    .gc_valid_i(gc_v), .gc_byte_i(gc_b), .addr_pins_i(pins),
    .slave_sel_o(sel), .irq_o(irq)
  );

  gc_host_model gc_host_model_i (
    .clk_i(clk), .gc_valid_o(gc_v), .gc_byte_o(gc_b), .addr_pins_o(pins)
  );

  // ******
  // Helpers
  // ******
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang(input logic stuck);
    if (stuck) begin
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      results();
    end
  endtask : hang

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int   n;
    logic ok;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    ok = 1'b0;
    // Answer is settled mid-cycle and stands until the accepting edge
    do begin
      @(negedge clk);
      ok = (rsp.pready === 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      @(posedge clk);
      n++;
    end while (!ok && n < 20);
    hang(!ok);
    req <= '0;
  endtask : apb

  task automatic wait_pwr(input logic v);
    int n;
    n = 0;
    while (pwr !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
    hang(pwr !== v);
  endtask : wait_pwr

  task automatic wait_done();
    int n;
    n = 0;
    rd = '0;
    while (rd[IRQ_DONE] !== 1'b1 && n < 400) begin
      apb(1'b0, OFS_STATUS, '0);
      n++;
    end
    hang(rd[IRQ_DONE] !== 1'b1);
  endtask : wait_done

  task automatic single(input rate_t r, input logic [RAW_W-1:0] v,
                        input logic [15:0] e);
    apb(1'b1, OFS_STATUS, 32'h3);
    raw <= v;
    apb(1'b1, OFS_CONFIG, {24'h0, 4'h9, r, 2'h0});
    wait_pwr(1'b1);
    wait_pwr(1'b0);
    apb(1'b0, OFS_RESULT, '0);
    chk(rd, {16'h0, e});
    apb(1'b0, OFS_CONFIG, '0);
    chk(rd, {24'h0, 4'h1, r, 2'h0});
    apb(1'b0, OFS_STATUS, '0);
    chk(rd[IRQ_DONE], 1'b1);
  endtask : single

  // ******
  // Scenarios
  // ******
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      chk(rd, (i == 0) ? 32'h0c : 32'h0);
    end
    apb(1'b1, 8'h14, 32'hffff_ffff);
    apb(1'b0, 8'h14, '0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    chk(sel, 2'h1);
  endtask : t_reset

  // Switching to single mode must let the running conversion finish
  task automatic t_stop();
    wait_pwr(1'b1);
    apb(1'b1, OFS_CONFIG, 32'h1c);
    chk(pwr, 1'b1);
    wait_pwr(1'b0);
    apb(1'b0, OFS_CONFIG, '0);
    chk(rd, 32'h1c);
    apb(1'b0, OFS_STATUS, '0);
    chk(rd[IRQ_DONE], 1'b1);
    repeat (400) @(posedge clk);
    chk(pwr, 1'b0);
  endtask : t_stop

  task automatic t_codes();
    int          n;
    logic [15:0] mx;
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 12 : (i == 1) ? 14 : (i == 2) ? 15 : 16;
      mx = 16'((1 << (n - 1)) - 1);
      single(rate_t'(i), 20'h08000, mx);
      single(rate_t'(i), 20'hf8000, ~mx);
      single(rate_t'(i), 20'h00000, 16'h0000);
      single(rate_t'(i), 20'hfffff, 16'hffff);
      single(rate_t'(i), 20'(1 << (16 - n)), 16'h0001);
    end
  endtask : t_codes

  // A second start during a conversion must neither restart nor queue
  task automatic t_ignore();
    apb(1'b1, OFS_STATUS, 32'h3);
    raw <= 20'h00100;
    apb(1'b1, OFS_CONFIG, 32'h9c);
    wait_pwr(1'b1);
    apb(1'b1, OFS_CONFIG, 32'h9c);
    apb(1'b0, OFS_STATUS, '0);
    chk(rd[IRQ_IGNORED], 1'b1);
    wait_pwr(1'b0);
    repeat (300) @(posedge clk);
    chk(pwr, 1'b0);
    apb(1'b0, OFS_RESULT, '0);
    chk(rd, 32'h0100);
  endtask : t_ignore

  task automatic t_cal();
    @(posedge clk);
    ofs <= 20'd40;
    gn <= 16'h8000;
    single(RATE_15, 20'd100, 16'd120);
    ofs <= '0;
    gn <= 16'h4000;
  endtask : t_cal

  task automatic t_irq();
    apb(1'b1, OFS_MASK, 32'h0);
    single(RATE_240, 20'h0, 16'h0);
    chk(irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h3);
    @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b0, OFS_STATUS, '0);
    chk(rd, 32'h0);
  endtask : t_irq

  task automatic t_gc();
    apb(1'b1, OFS_CONFIG, 32'h1f);
    @(negedge clk);
    chk(gain, 2'h3);
    gc_host_model_i.set_pins(2'h2);
    gc_host_model_i.send_gc(8'h04);
    repeat (8) @(posedge clk);
    chk(sel, 2'h2);
    apb(1'b0, OFS_CONFIG, '0);
    chk(rd, 32'h1f);
    apb(1'b0, OFS_SLAVE, '0);
    chk(rd, 32'h2);
    gc_host_model_i.set_pins(2'h1);
    gc_host_model_i.send_gc(8'h06);
    repeat (8) @(posedge clk);
    chk(sel, 2'h1);
    apb(1'b0, OFS_CONFIG, '0);
    chk(rd, 32'h0c);
    chk(gain, 2'h0);
  endtask : t_gc

  // Raw input changes between results; no host start in between
  task automatic t_cont();
    apb(1'b1, OFS_CONFIG, 32'h0);
    raw <= 20'h00010;
    apb(1'b1, OFS_STATUS, 32'h3);
    wait_done();
    apb(1'b0, OFS_RESULT, '0);
    chk(rd, 32'h0001);
    raw <= 20'hf0000;
    apb(1'b1, OFS_STATUS, 32'h3);
    wait_done();
    apb(1'b0, OFS_RESULT, '0);
    chk(rd, 32'hf800);
    apb(1'b1, OFS_CONFIG, 32'h10);
    wait_pwr(1'b0);
  endtask : t_cont

  initial begin
    clk = 1'b0;
    osc = 1'b0;
    reset = 1'b1;
    req = '0;
    raw = '0;
    ofs = '0;
    gn = 16'h4000;
    rd = '0;
    err = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_stop();
    t_codes();
    t_ignore();
    t_cal();
    t_irq();
    t_gc();
    t_cont();
    results();
  end
endmodule : conv_seq_test
